// ---- common/two_wire_consts.svh ----
// Purpose: Shared constants for the two-wire bus ends.
// Assumes: mclk at 250 MHz.
// Notes:   Times are in ns; cycle counts derive from them.
`ifndef TWO_WIRE_CONSTS_SVH
`define TWO_WIRE_CONSTS_SVH

`define TW_MCLK_NS       4
`define TW_SCL_HALF_NS   1250
// A half period is a least time, so it rounds up.
`define TW_SCL_HALF_CYC  ((`TW_SCL_HALF_NS + `TW_MCLK_NS - 1) / `TW_MCLK_NS)
`define TW_BYTE_BITS     4'h8
`define TW_ACK_BIT       4'h8
`define TW_GCALL_ADDR    7'h00
`define TW_RSVD_TOP      4'hf

`endif

// ---- common/two_wire_if.sv ----
// Purpose: Open-drain clock and data lines between the two ends.
// Assumes: Pull-ups hold each line high when nobody drives it.
// Notes:   The bench may add further parties by and-ing its own terms.
`timescale 1ns/100ps
interface two_wire_if;
  logic m_scl_o;
  logic m_scl_oe_n;
  logic m_sda_o;
  logic m_sda_oe_n;
  logic s_scl_o;
  logic s_scl_oe_n;
  logic s_sda_o;
  logic s_sda_oe_n;
  logic scl;
  logic sda;

  // Wired-AND: a line is low if any party enables its low output.
  assign scl = (m_scl_oe_n | m_scl_o) & (s_scl_oe_n | s_scl_o);
  assign sda = (m_sda_oe_n | m_sda_o) & (s_sda_oe_n | s_sda_o);

  modport master (output m_scl_o, m_scl_oe_n, m_sda_o, m_sda_oe_n,
                  input  scl, sda);
  modport slave  (output s_scl_o, s_scl_oe_n, s_sda_o, s_sda_oe_n,
                  input  scl, sda);
endinterface : two_wire_if

// ---- common/two_wire_pkg.sv ----
// Purpose: Types shared by both ends of the two-wire bus.
// Assumes: Nothing beyond the constants header.
// Notes:   Command codes are left to the tool.
package two_wire_pkg;
  typedef logic [6:0] addr_t;
  typedef logic [7:0] byte_t;
  typedef enum logic [1:0] {CMD_START, CMD_WRITE, CMD_READ, CMD_STOP} cmd_e;
  typedef enum {S_IDLE, S_ADDR, S_ADDR_ACK, S_RX, S_RX_ACK,
                S_LOAD, S_TX, S_TX_ACK} slv_state_e;
  typedef enum {M_IDLE, M_HOLD, M_START, M_RS_A, M_RS_B, M_BIT_LOW,
                M_BIT_HIGH, M_STOP_A, M_STOP_B, M_STOP_C} mst_state_e;
endpackage : two_wire_pkg

// ---- dv/tb.sv ----
// Purpose: Self-checking bench for the master and slave ends.
// Assumes: One master and one slave on pulled-up lines.
// Notes:   Queues model the bytes; a monitor reads SDA off the wire.
`timescale 1ns/100ps
module tb;
  import two_wire_pkg::*;
  logic        mclk, rst, cmd_valid, cmd_nack, cmd_ready, rsp_valid;
  logic        rsp_ack, pr, gc, busy, rx_valid, rx_ready, tx_valid;
  logic        tx_ready, bus_busy, start_seen, stop_seen, addressed;
  logic        addr_read, addr_gcall, tx_nacked, rx_hold, took, ea;
  logic        scl_q, sda_q, w_ack;
  logic [3:0]  nbit;
  logic [17:0] e;
  cmd_e        cmd;
  byte_t       cmd_data, rsp_data, rx_data, tx_data, w_byte, sh;
  addr_t       own;
  byte_t       rxq[$], rdq[$];
  int          errors, n_tests, n_start, n_stop, n_nak, e_start;
  int          e_stop, e_nak, n, n_addr, e_addr;
  integer      seed = 32'hc7ac_f638;
  logic [17:0] tbl [10] = '{{7'h2a, 7'h2a, 4'h0}, {7'h2a, 7'h2a, 4'h8},
    {7'h2a, 7'h2b, 4'h0}, {7'h2a, 7'h2a, 4'h2}, {7'h2a, 7'h00, 4'h4},
    {7'h2a, 7'h00, 4'h0}, {7'h2a, 7'h00, 4'hc}, {7'h7a, 7'h7a, 4'h0},
    {7'h00, 7'h00, 4'h0}, {7'h2a, 7'h2a, 4'h1}};

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  two_wire_if i_two_wire_if ();
  wire scl = i_two_wire_if.scl;
  wire sda = i_two_wire_if.sda;
  // A 128 ns link period is close to the bench rate and keeps runs short.
  two_wire_master #(.HALF_CYC(16)) i_two_wire_master (
    .mclk(mclk), .rst(rst), .bus(i_two_wire_if), .cmd_valid(cmd_valid),
    .cmd(cmd), .cmd_data(cmd_data), .cmd_nack(cmd_nack),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_ack(rsp_ack));
  two_wire_slave i_two_wire_slave (
    .mclk(mclk), .rst(rst), .bus(i_two_wire_if),
    .serial_bus_power_reduce_bit(pr), .own_addr(own), .gcall_enable(gc),
    .slave_busy(busy), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .bus_busy(bus_busy), .start_seen(start_seen),
    .stop_seen(stop_seen), .addressed(addressed), .addr_read(addr_read),
    .addr_gcall(addr_gcall), .tx_nacked(tx_nacked));
  two_wire_asserts i_two_wire_asserts (
    .mclk(mclk), .rst(rst), .scl(scl), .sda(sda),
    .m_scl_o(i_two_wire_if.m_scl_o), .m_scl_oe_n(i_two_wire_if.m_scl_oe_n),
    .m_sda_o(i_two_wire_if.m_sda_o), .m_sda_oe_n(i_two_wire_if.m_sda_oe_n),
    .s_scl_o(i_two_wire_if.s_scl_o), .s_scl_oe_n(i_two_wire_if.s_scl_oe_n),
    .s_sda_o(i_two_wire_if.s_sda_o), .s_sda_oe_n(i_two_wire_if.s_sda_oe_n));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic stop_test();
    $display("Counts: %0d compared, %0d wrong", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test

  function automatic logic exp_ack(addr_t o, addr_t a, logic [3:0] f);
    logic mine;
    mine = a == o && o != 7'h00 && o[6:3] != 4'hf;
    // A busy slave stays off the line for a general call as well.
    return !f[0] && !f[1] && (mine || (a == 7'h00 && !f[3] && f[2]));
  endfunction : exp_ack

  task automatic mcmd(input cmd_e c, input byte_t d, input logic nk);
    int k;
    k = 0;
    @(negedge mclk);
    cmd_valid = 1'b1;
    cmd = c;
    cmd_data = d;
    cmd_nack = nk;
    // cmd_ready is a flop, so its level here is what the next edge sees.
    while (cmd_ready !== 1'b1 && k < 9000) begin
      @(negedge mclk);
      k++;
    end
    @(negedge mclk);
    cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1 && k < 9000) begin
      @(negedge mclk);
      k++;
    end
    if (k >= 9000) chk(1'b0, 1'b1);
  endtask : mcmd

  task automatic st(input addr_t a, input logic rw, output logic ok);
    ok = exp_ack(own, a, {rw, gc, busy, pr});
    mcmd(CMD_START, {a, rw}, 1'b0);
    chk(rsp_ack, ok);
    if (!(a == 7'h00 && rw)) begin
      chk(w_byte, {a, rw});
      chk(w_ack, !ok);
      chk(bus_busy, !pr);
    end
    if (ok) begin
      e_addr++;
      chk(addr_read, rw);
      chk(addr_gcall, a == 7'h00);
    end
  endtask : st

  task automatic stp(input logic so);
    mcmd(CMD_STOP, 8'h00, 1'b0);
    chk(rsp_ack, so);
    chk(bus_busy, 1'b0);
    if (so && !pr) begin
      e_start++;
      e_stop++;
    end
  endtask : stp

  task automatic wr();
    byte_t d;
    logic  ok;
    d = 8'($random(seed));
    ok = rxq.size() < 2;
    // The byte can leave the slave before its ack ends, so queue it first.
    if (ok) rxq.push_back(d);
    mcmd(CMD_WRITE, d, 1'b0);
    chk(rsp_ack, ok);
    chk(w_byte, d);
    chk(w_ack, !ok);
  endtask : wr

  task automatic rd(input logic nk);
    byte_t x;
    mcmd(CMD_READ, 8'h00, nk);
    x = rdq.pop_front();
    chk(rsp_data, x);
    chk(w_byte, x);
    chk(w_ack, nk);
    e_nak += nk;
  endtask : rd

  // Wire monitor: bits count from each start; the ninth is the ack.
  always @(posedge mclk) begin
    scl_q <= scl;
    sda_q <= sda;
    if (rst || (scl_q && scl && sda_q && !sda)) begin
      nbit <= 4'h0;
    end else if (scl && !scl_q) begin
      sh <= {sh[6:0], sda};
      nbit <= (nbit == 4'h8) ? 4'h0 : nbit + 4'h1;
      if (nbit == 4'h8) begin
        w_byte <= sh;
        w_ack <= sda;
      end
    end
  end

  always @(posedge mclk) begin
    n_start += (start_seen === 1'b1);
    n_stop += (stop_seen === 1'b1);
    n_nak += (tx_nacked === 1'b1);
    n_addr += (addressed === 1'b1);
    if (rx_valid === 1'b1 && rx_ready === 1'b1)
      chk(rx_data, rxq.pop_front());
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      rdq.push_back(tx_data);
      took = 1'b1;
    end
  end

  // Random stalls on both streams make the slave stretch and buffer.
  always @(negedge mclk) begin
    rx_ready <= !rx_hold && 1'($random(seed));
    if (took) begin
      tx_valid <= 1'b0;
      tx_data <= 8'($random(seed));
      took = 1'b0;
    end else if (!tx_valid) begin
      tx_valid <= 1'($random(seed));
    end
  end

  initial begin
    // About 50,000 cycles, more than twice what the tests need.
    #200_000;
    errors++;
    stop_test();
  end

  initial begin
    rst = 1'b1;
    {cmd_valid, cmd_nack, pr, gc, busy, rx_hold, tx_valid} = 7'h00;
    {rx_ready, took} = 2'h0;
    cmd = CMD_STOP;
    cmd_data = 8'h00;
    tx_data = 8'h00;
    own = 7'h2a;
    repeat (6) @(negedge mclk);
    rst = 1'b0;
    repeat (3) @(negedge mclk);
    chk(scl, 1'b1);
    chk(sda, 1'b1);
    chk(bus_busy, 1'b0);
    $display("T1 reset done");
    for (int i = 0; i < 16; i++) begin
      e = tbl[i % 10];
      if (i >= 10) begin
        e[17:11] = 7'($random(seed));
        e[10:4] = 7'($random(seed));
        if (seed[0]) e[10:4] = e[17:11];
        e[3:2] = 2'($random(seed));
      end
      {own, gc, busy, pr} = {e[17:11], e[2:0]};
      // Leave the slave's synchronisers time after a power change.
      repeat (4) @(negedge mclk);
      st(e[10:4], e[3], ea);
      if (ea && e[3]) rd(1'b1);
      else if (ea) wr();
      stp(!(e[10:4] == 7'h00 && e[3]));
    end
    {own, gc, busy, pr} = {7'h2a, 3'h0};
    $display("T2 address table done");
    st(own, 1'b0, ea);
    repeat (3) wr();
    st(own, 1'b1, ea);
    e_start++;
    rd(1'b0);
    rd(1'b0);
    rd(1'b1);
    stp(1'b1);
    $display("T3 repeated start done");
    rx_hold = 1'b1;
    st(own, 1'b0, ea);
    repeat (3) wr();
    stp(1'b1);
    rx_hold = 1'b0;
    n = 0;
    while (rxq.size() > 0 && n < 200) begin
      @(negedge mclk);
      n++;
    end
    chk(8'(rxq.size()), 8'h00);
    $display("T4 buffer full done");
    chk(8'(n_start), 8'(e_start));
    chk(8'(n_stop), 8'(e_stop));
    chk(8'(n_nak), 8'(e_nak));
    chk(8'(n_addr), 8'(e_addr));
    stop_test();
  end
endmodule : tb

// ---- dv/two_wire_asserts.sv ----
// Purpose: Line-level checks between the two-wire master and slave.
// Assumes: Master half period of at least nine mclk cycles.
// Notes:   Watches only interface signals, so no bind is used.
`timescale 1ns/100ps
module two_wire_asserts (
  input wire logic mclk,
  input wire logic rst,
  input wire logic m_scl_o,
  input wire logic m_scl_oe_n,
  input wire logic m_sda_o,
  input wire logic m_sda_oe_n,
  input wire logic s_scl_o,
  input wire logic s_scl_oe_n,
  input wire logic s_sda_o,
  input wire logic s_sda_oe_n,
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  sequence start_cond;
    scl && $past(scl) && $fell(sda);
  endsequence
  sequence stop_cond;
    scl && $past(scl) && $rose(sda);
  endsequence

  drive_low_a: assert property (
    !m_scl_o && !m_sda_o && !s_scl_o && !s_sda_o)
    else $error("A driver offers a high level.");
  start_hold_a: assert property (
    start_cond |=> scl [*8])
    else $error("Clock fell too soon after a start.");
  stop_idle_a: assert property (
    stop_cond |=> (scl && sda) [*8])
    else $error("Lines did not stay idle after a stop.");
  scl_fall_a: assert property (
    $fell(scl) |-> !m_scl_oe_n)
    else $error("Clock fell without the master pulling it.");
  stretch_a: assert property (
    $fell(s_scl_oe_n) |-> !$past(scl))
    else $error("Slave pulled a high clock low.");
  mst_high_a: assert property (
    $rose(scl) |-> m_scl_oe_n [*8])
    else $error("Master shortened the clock high phase.");
  slv_sda_a: assert property (
    scl && $past(scl) |-> $stable(s_sda_oe_n))
    else $error("Slave moved data while the clock was high.");
  mst_sda_a: assert property (
    $changed(m_sda_oe_n) && scl |=> scl [*4])
    else $error("Master moved data in a clock high phase.");
endmodule : two_wire_asserts

// ---- rtl/two_wire_master.sv ----
// Purpose: Bus master end: makes SCL, START, STOP and moves bytes.
// Assumes: A single master; no arbitration is attempted.
// Notes:   One command at a time; each answers with one rsp pulse.
`timescale 1ns/100ps
`include "two_wire_consts.svh"
module two_wire_master #(
  parameter int HALF_CYC = `TW_SCL_HALF_CYC
) (
  input  wire logic                mclk,
  input  wire logic                rst,
  two_wire_if.master               bus,
  input  wire logic                cmd_valid,
  input  wire two_wire_pkg::cmd_e  cmd,
  input  wire two_wire_pkg::byte_t cmd_data,
  input  wire logic                cmd_nack,
  output logic                     cmd_ready,
  output logic                     rsp_valid,
  output two_wire_pkg::byte_t      rsp_data,
  output logic                     rsp_ack
);
  import two_wire_pkg::*;

  localparam logic [15:0] HALF_M1 = 16'(HALF_CYC - 1);

  mst_state_e  state_ff, nxt_state;
  logic [15:0] tmr_ff, nxt_tmr;
  logic [3:0]  bit_ff, nxt_bit;
  byte_t       sh_ff, nxt_sh;
  logic        rd_ff, nxt_rd, nack_ff, nxt_nack, ack_ff, nxt_ack, rsp_go;
  logic        scl_s1_ff, scl_s2_ff, scl_s3_ff;
  logic        sda_s1_ff, sda_s2_ff, sda_s3_ff;
  logic        busy_ff, scl_drv_ff, sda_drv_ff, lo_ff;

  wire accept   = cmd_valid & cmd_ready;
  wire tdone    = (tmr_ff == 16'h0000);
  wire gc_read  = (cmd_data[7:1] == `TW_GCALL_ADDR) & cmd_data[0];
  wire start_c  = scl_s2_ff & scl_s3_ff & sda_s3_ff & !sda_s2_ff;
  wire stop_c   = scl_s2_ff & scl_s3_ff & !sda_s3_ff & sda_s2_ff;
  wire bit_low  = (bit_ff == `TW_ACK_BIT) ? (rd_ff & !nack_ff)
                                          : (!rd_ff & !sh_ff[7]);
  wire in_bit   = (state_ff == M_BIT_LOW) | (state_ff == M_BIT_HIGH);
  wire scl_drv  = (state_ff == M_BIT_LOW) | (state_ff == M_HOLD) |
                  (state_ff == M_STOP_A) | (state_ff == M_RS_A);
  wire sda_drv  = (state_ff == M_START) | (state_ff == M_STOP_A) |
                  (state_ff == M_STOP_B) | (in_bit & bit_low);
  wire idle_rdy = (state_ff == M_IDLE) & !busy_ff;

  always_comb begin
    nxt_state = state_ff;
    nxt_tmr   = tdone ? tmr_ff : tmr_ff - 16'h0001;
    nxt_bit   = bit_ff;
    nxt_sh    = sh_ff;
    nxt_rd    = rd_ff;
    nxt_nack  = nack_ff;
    nxt_ack   = ack_ff;
    rsp_go    = 1'b0;
    case (state_ff)
      M_IDLE: begin
        if (accept) begin
          // Only an address may follow a START, never a bare STOP.
          if (cmd == CMD_START && !gc_read) begin
            nxt_sh    = cmd_data;
            nxt_rd    = 1'b0;
            nxt_tmr   = HALF_M1;
            nxt_state = M_START;
          end else begin
            nxt_ack = 1'b0;
            rsp_go  = 1'b1;
          end
        end
      end
      M_HOLD: begin
        if (accept) begin
          nxt_tmr = HALF_M1;
          nxt_bit = 4'h0;
          case (cmd)
            CMD_START: begin
              if (gc_read) begin
                nxt_ack = 1'b0;
                rsp_go  = 1'b1;
              end else begin
                nxt_sh    = cmd_data;
                nxt_rd    = 1'b0;
                nxt_state = M_RS_A;
              end
            end
            CMD_WRITE: begin
              nxt_sh    = cmd_data;
              nxt_rd    = 1'b0;
              nxt_state = M_BIT_LOW;
            end
            CMD_READ: begin
              nxt_rd    = 1'b1;
              nxt_nack  = cmd_nack;
              nxt_state = M_BIT_LOW;
            end
            default: nxt_state = M_STOP_A;
          endcase
        end
      end
      M_RS_A: begin
        if (tdone) begin
          nxt_tmr   = HALF_M1;
          nxt_state = M_RS_B;
        end
      end
      M_START: begin
        if (tdone) begin
          nxt_tmr   = HALF_M1;
          nxt_bit   = 4'h0;
          nxt_state = M_BIT_LOW;
        end
      end
      M_BIT_LOW: begin
        if (tdone) begin
          nxt_tmr   = HALF_M1;
          nxt_state = M_BIT_HIGH;
        end
      end
      M_STOP_A: begin
        if (tdone) begin
          nxt_tmr   = HALF_M1;
          nxt_state = M_STOP_B;
        end
      end
      M_STOP_C: begin
        if (tdone) begin
          nxt_ack   = 1'b1;
          rsp_go    = 1'b1;
          nxt_state = M_IDLE;
        end
      end
      default: begin
        // High phase is timed only once SCL is really high.
        if (!scl_s2_ff) begin
          nxt_tmr = HALF_M1;
        end else if (tdone) begin
          nxt_tmr = HALF_M1;
          if (state_ff == M_RS_B) begin
            nxt_state = M_START;
          end else if (state_ff == M_STOP_B) begin
            nxt_state = M_STOP_C;
          end else if (bit_ff == `TW_ACK_BIT) begin
            nxt_ack   = !sda_s2_ff;
            rsp_go    = 1'b1;
            nxt_state = M_HOLD;
          end else begin
            nxt_sh    = {sh_ff[6:0], rd_ff & sda_s2_ff};
            nxt_bit   = bit_ff + 4'h1;
            nxt_state = M_BIT_LOW;
          end
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      {scl_s1_ff, scl_s2_ff, scl_s3_ff} <= 3'h7;
      {sda_s1_ff, sda_s2_ff, sda_s3_ff} <= 3'h7;
    end else begin
      {scl_s1_ff, scl_s2_ff, scl_s3_ff} <= {bus.scl, scl_s1_ff, scl_s2_ff};
      {sda_s1_ff, sda_s2_ff, sda_s3_ff} <= {bus.sda, sda_s1_ff, sda_s2_ff};
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_ff <= M_IDLE;
      tmr_ff   <= 16'h0000;
      bit_ff   <= 4'h0;
      sh_ff    <= 8'h00;
      rd_ff    <= 1'b0;
      nack_ff  <= 1'b0;
      ack_ff   <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      tmr_ff   <= nxt_tmr;
      bit_ff   <= nxt_bit;
      sh_ff    <= nxt_sh;
      rd_ff    <= nxt_rd;
      nack_ff  <= nxt_nack;
      ack_ff   <= nxt_ack;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      busy_ff    <= 1'b0;
      scl_drv_ff <= 1'b0;
      sda_drv_ff <= 1'b0;
      lo_ff      <= 1'b0;
      cmd_ready  <= 1'b0;
      rsp_valid  <= 1'b0;
      rsp_data   <= 8'h00;
      rsp_ack    <= 1'b0;
    end else begin
      busy_ff    <= start_c | (busy_ff & !stop_c);
      scl_drv_ff <= scl_drv;
      sda_drv_ff <= sda_drv;
      lo_ff      <= 1'b0;
      cmd_ready  <= (idle_rdy | (state_ff == M_HOLD)) & !accept;
      rsp_valid  <= rsp_go;
      rsp_data   <= rsp_go ? sh_ff : rsp_data;
      rsp_ack    <= rsp_go ? nxt_ack : rsp_ack;
    end
  end

  assign bus.m_scl_o    = lo_ff;
  assign bus.m_sda_o    = lo_ff;
  assign bus.m_scl_oe_n = !scl_drv_ff;
  assign bus.m_sda_oe_n = !sda_drv_ff;
endmodule : two_wire_master

// ---- rtl/two_wire_slave.sv ----
// Purpose: Bus slave end: framing, address match, byte transfer.
// Assumes: SCL half period well above six mclk cycles.
// Notes:   Received bytes pass a two-entry buffer whose head is rx_data.
//
// Contract
// - SDA steady while SCL high, except conditions.
// - Conditions are SDA changes with SCL high.
// - Bus busy from START until STOP.
// - Repeated START acts like START, bus stays busy.
// - Address packet: seven address, direction, acknowledge.
// - Direction one reads, zero writes.
// - Addressed slave pulls SDA low in ninth cycle.
// - Busy slave leaves SDA high in acknowledge.
// - Address goes out MSB first, then direction.
// - All-zero write address is general call.
// - Master never sends general call with read.
// - Addresses 1111xxx are reserved, never assigned.
// - Data packet: eight data bits plus acknowledge.
// - Master clocks; receiver supplies the acknowledge.
// - Low ninth bit acknowledges, high means not.
// - Receiver not-acknowledges when done or full.
// - Data byte goes out MSB first.
// - Both lines open-drain, wired-AND.
// - Interface idle while power-reduce bit set.
// - Only master frames; slave answers its address.
// - No bare START then STOP frame.
// - Slave may stretch SCL low; master waits.
`timescale 1ns/100ps
`include "two_wire_consts.svh"
module two_wire_slave (
  input  wire logic                mclk,
  input  wire logic                rst,
  two_wire_if.slave                bus,
  input  wire logic                serial_bus_power_reduce_bit,
  input  wire two_wire_pkg::addr_t own_addr,
  input  wire logic                gcall_enable,
  input  wire logic                slave_busy,
  output two_wire_pkg::byte_t      rx_data,
  output logic                     rx_valid,
  input  wire logic                rx_ready,
  input  wire two_wire_pkg::byte_t tx_data,
  input  wire logic                tx_valid,
  output logic                     tx_ready,
  output logic                     bus_busy,
  output logic                     start_seen,
  output logic                     stop_seen,
  output logic                     addressed,
  output logic                     addr_read,
  output logic                     addr_gcall,
  output logic                     tx_nacked
);
  import two_wire_pkg::*;

  function automatic logic addr_hit(input addr_t a, input addr_t own,
                                    input logic rw, input logic gc_en);
    logic own_ok;
    own_ok   = (own[6:3] != `TW_RSVD_TOP) && (own != `TW_GCALL_ADDR);
    addr_hit = (own_ok && a == own) ||
               (gc_en && a == `TW_GCALL_ADDR && !rw);
  endfunction : addr_hit

  slv_state_e state_ff, nxt_state;
  logic [3:0] cnt_ff, nxt_cnt;
  byte_t      sh_ff, nxt_sh, spare_ff;
  logic       mack_ff, nxt_mack, push, take, hit_go, nack_go;
  logic       scl_s1_ff, scl_s2_ff, scl_s3_ff;
  logic       sda_s1_ff, sda_s2_ff, sda_s3_ff;
  logic       spare_v_ff, load_d_ff, lo_ff, scl_oe_n_ff, sda_oe_n_ff;

  wire enable    = !serial_bus_power_reduce_bit;
  wire scl_rise  = scl_s2_ff & !scl_s3_ff;
  wire scl_fall  = !scl_s2_ff & scl_s3_ff;
  wire start_c   = scl_s2_ff & scl_s3_ff & sda_s3_ff & !sda_s2_ff;
  wire stop_c    = scl_s2_ff & scl_s3_ff & !sda_s3_ff & sda_s2_ff;
  wire byte_done = scl_fall & (cnt_ff == `TW_BYTE_BITS);
  wire rx_room   = !(rx_valid & spare_v_ff);
  wire hit       = addr_hit(sh_ff[7:1], own_addr, sh_ff[0], gcall_enable);
  wire serve     = hit & !slave_busy & (sh_ff[0] | rx_room);
  wire drive_sda = (state_ff == S_ADDR_ACK) | (state_ff == S_RX_ACK) |
                   ((state_ff == S_TX) & !sh_ff[7]);
  wire in_load   = (state_ff == S_LOAD);

  // Two-entry buffer: rx_data is the head, spare_ff the second word.
  wire pop       = rx_valid & rx_ready;
  wire head_free = !rx_valid | pop;
  wire nxt_rx_v  = head_free ? (spare_v_ff | push) : 1'b1;
  wire nxt_sp_v  = spare_v_ff ? (!head_free | push) : (push & !head_free);
  wire sp_write  = push & (spare_v_ff ? head_free : !head_free);

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_sh    = sh_ff;
    nxt_mack  = mack_ff;
    push      = 1'b0;
    take      = 1'b0;
    hit_go    = 1'b0;
    nack_go   = 1'b0;
    case (state_ff)
      S_ADDR, S_RX: begin
        if (scl_rise) begin
          nxt_sh  = {sh_ff[6:0], sda_s2_ff};
          nxt_cnt = cnt_ff + 4'h1;
        end else if (byte_done && state_ff == S_ADDR) begin
          // A busy slave simply stays off the line.
          hit_go    = serve;
          nxt_state = serve ? S_ADDR_ACK : S_IDLE;
        end else if (byte_done) begin
          push      = rx_room;
          nxt_state = rx_room ? S_RX_ACK : S_IDLE;
        end
      end
      S_ADDR_ACK: begin
        if (scl_fall) begin
          nxt_cnt   = 4'h0;
          nxt_state = sh_ff[0] ? S_LOAD : S_RX;
        end
      end
      S_RX_ACK: begin
        if (scl_fall) begin
          nxt_cnt   = 4'h0;
          nxt_state = S_RX;
        end
      end
      S_LOAD: begin
        if (tx_valid && tx_ready) begin
          take      = 1'b1;
          nxt_sh    = tx_data;
          nxt_cnt   = 4'h0;
          nxt_state = S_TX;
        end
      end
      S_TX: begin
        if (scl_rise) begin
          nxt_cnt = cnt_ff + 4'h1;
        end else if (byte_done) begin
          nxt_state = S_TX_ACK;
        end else if (scl_fall) begin
          nxt_sh = {sh_ff[6:0], 1'b0};
        end
      end
      S_TX_ACK: begin
        if (scl_rise) begin
          nxt_mack = !sda_s2_ff;
        end else if (scl_fall) begin
          nack_go   = !mack_ff;
          nxt_state = mack_ff ? S_LOAD : S_IDLE;
        end
      end
      default: nxt_state = S_IDLE;
    endcase
    if (start_c) begin
      nxt_cnt   = 4'h0;
      nxt_state = S_ADDR;
    end else if (stop_c) begin
      nxt_state = S_IDLE;
    end
    if (!enable) begin
      nxt_state = S_IDLE;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      {scl_s1_ff, scl_s2_ff, scl_s3_ff} <= 3'h7;
      {sda_s1_ff, sda_s2_ff, sda_s3_ff} <= 3'h7;
    end else begin
      {scl_s1_ff, scl_s2_ff, scl_s3_ff} <= {bus.scl, scl_s1_ff, scl_s2_ff};
      {sda_s1_ff, sda_s2_ff, sda_s3_ff} <= {bus.sda, sda_s1_ff, sda_s2_ff};
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_ff <= S_IDLE;
      cnt_ff   <= 4'h0;
      sh_ff    <= 8'h00;
      mack_ff  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      sh_ff    <= nxt_sh;
      mack_ff  <= nxt_mack;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rx_valid   <= 1'b0;
      rx_data    <= 8'h00;
      spare_v_ff <= 1'b0;
      spare_ff   <= 8'h00;
    end else begin
      rx_valid   <= nxt_rx_v;
      rx_data    <= !head_free ? rx_data :
                    spare_v_ff ? spare_ff : (push ? sh_ff : rx_data);
      spare_v_ff <= nxt_sp_v;
      spare_ff   <= sp_write ? sh_ff : spare_ff;
    end
  end

  // SDA changes one cycle before a stretched SCL is let go, for setup.
  always_ff @(posedge mclk) begin
    if (rst) begin
      load_d_ff   <= 1'b0;
      lo_ff       <= 1'b0;
      scl_oe_n_ff <= 1'b1;
      sda_oe_n_ff <= 1'b1;
      tx_ready    <= 1'b0;
      bus_busy    <= 1'b0;
      start_seen  <= 1'b0;
      stop_seen   <= 1'b0;
      addressed   <= 1'b0;
      addr_read   <= 1'b0;
      addr_gcall  <= 1'b0;
      tx_nacked   <= 1'b0;
    end else begin
      load_d_ff   <= in_load;
      lo_ff       <= 1'b0;
      scl_oe_n_ff <= !(in_load | load_d_ff);
      sda_oe_n_ff <= !drive_sda;
      tx_ready    <= in_load & !take & enable;
      bus_busy    <= enable & (start_c | (bus_busy & !stop_c));
      start_seen  <= enable & start_c;
      stop_seen   <= enable & stop_c;
      addressed   <= hit_go;
      addr_read   <= hit_go ? sh_ff[0] : addr_read;
      addr_gcall  <= hit_go ? (sh_ff[7:1] == `TW_GCALL_ADDR) : addr_gcall;
      tx_nacked   <= nack_go;
    end
  end

  assign bus.s_scl_o    = lo_ff;
  assign bus.s_sda_o    = lo_ff;
  assign bus.s_scl_oe_n = scl_oe_n_ff;
  assign bus.s_sda_oe_n = sda_oe_n_ff;
endmodule : two_wire_slave
